// ---- src/srh_ctrl.sv ----
`timescale 1ns/1ps

// How it works
// - both strobes stay high for 2 ms after reset before first cycle
// - write strobe falls before chip strobe on early writes
// - chip strobe low between 200 ns and 10,000 ns per cycle
// - chip strobe stays high at least 100 ns between cycles
// - successive chip strobe falls at least 310 ns apart
// - write data is on the pin before the later strobe falls
// - write data held 170 ns past chip fall and 70 ns past write fall
// - write strobe low at least 60 ns
// - write strobe falls at least 70 ns before chip strobe rises
// - write strobe held low 150 ns from chip strobe fall
// - reads keep write strobe high through the chip strobe fall
// - modify time user chosen, bounded so chip strobe stays under max
// - read-modify-write cycles spaced at least 385 ns start to start
module srh_ctrl #(
	parameter int ADDR_W        = srh_pkg::ADDR_W,
	parameter int POWERUP_CYC   = srh_pkg::POWERUP_CYC,
	parameter int ACCESS_CYC    = srh_pkg::ACCESS_CYC,
	parameter int ACT_MIN_CYC   = srh_pkg::ACT_MIN_CYC,
	parameter int ACT_MAX_CYC   = srh_pkg::ACT_MAX_CYC,
	parameter int PRECHARGE_CYC = srh_pkg::PRECHARGE_CYC,
	parameter int CYCLE_CYC     = srh_pkg::CYCLE_CYC,
	parameter int RMW_CYC       = srh_pkg::RMW_CYC
) (
	input  wire logic               clk,
	input  wire logic               sys_rst,
	input  wire logic               req_valid,
	output logic                    req_ready,
	input  wire srh_pkg::srh_req_t  req,
	output logic                    rsp_valid,
	output logic                    rsp_rdata,
	output logic                    mod_ready,
	input  wire logic               mod_valid,
	input  wire logic               mod_wdata,
	output logic                    op_done,
	output logic                    link_ready,
	output srh_pkg::srh_pins_t      mem,
	input  wire logic               mem_dout
);

	// ----------------------------------------------------------------
	// derived limits
	// ----------------------------------------------------------------
	// ce low for a read or early write: access plus one sampling edge,
	// the minimum pulse, the write-strobe hold and the data hold
	localparam int ACT_A   = (ACT_MIN_CYC > ACCESS_CYC + 1) ?
		ACT_MIN_CYC : ACCESS_CYC + 1;
	localparam int ACT_B   = (srh_pkg::WE_HOLD_CYC > srh_pkg::DHOLD_CE_CYC) ?
		srh_pkg::WE_HOLD_CYC : srh_pkg::DHOLD_CE_CYC;
	localparam int ACT_END = (ACT_A > ACT_B) ? ACT_A : ACT_B;
	localparam int WE_A    = (srh_pkg::WE_PULSE_CYC > srh_pkg::WE_LEAD_CYC) ?
		srh_pkg::WE_PULSE_CYC : srh_pkg::WE_LEAD_CYC;
	localparam int WE_LOW  = (WE_A > srh_pkg::DHOLD_WE_CYC) ?
		WE_A : srh_pkg::DHOLD_WE_CYC;
	localparam int MOD_END = ACT_MAX_CYC - WE_LOW - 3;
	localparam int TW      = $clog2(ACT_MAX_CYC + RMW_CYC + 2);

	generate
		if (ADDR_W != srh_pkg::ADDR_W) begin : g_bad_addr
			$error("srh_ctrl: ADDR_W must match 4096 words");
		end
		if (MOD_END <= ACT_END || ACT_MAX_CYC < ACT_END + WE_LOW + 4)
		begin : g_bad_max
			$error("srh_ctrl: ACT_MAX_CYC too short for a modify cycle");
		end
		if (PRECHARGE_CYC < 1 || CYCLE_CYC < 1 || RMW_CYC < 1)
		begin : g_bad_gap
			$error("srh_ctrl: spacing limits must be at least 1");
		end
		if (POWERUP_CYC < 1 || ACCESS_CYC < 1 || ACT_MIN_CYC < 1)
		begin : g_bad_cyc
			$error("srh_ctrl: timing limits must be at least 1");
		end
		// the timers saturate; a gap beyond their reach would never end
		if (CYCLE_CYC > ACT_MAX_CYC + RMW_CYC ||
			PRECHARGE_CYC > ACT_MAX_CYC + RMW_CYC)
		begin : g_bad_reach
			$error("srh_ctrl: spacing limits beyond timer reach");
		end
	endgenerate

	localparam logic [TW-1:0] ACT_LAST = TW'(ACT_END - 1);
	localparam logic [TW-1:0] WE_LAST  = TW'(WE_LOW - 1);
	localparam logic [TW-1:0] PRE_LAST = TW'(PRECHARGE_CYC - 1);
	localparam logic [TW-1:0] CYC_LAST = TW'(CYCLE_CYC - 1);
	localparam logic [TW-1:0] RMW_LAST = TW'(RMW_CYC - 1);
	localparam logic [TW-1:0] MOD_LAST = TW'(MOD_END);

	typedef enum logic [2:0] {
		ST_POWERUP,
		ST_IDLE,
		ST_SETUP,
		ST_ACTIVE,
		ST_MODIFY,
		ST_DATA,
		ST_WRITE,
		ST_PRECHARGE
	} srh_state_t;

	// ----------------------------------------------------------------
	// state and timers
	// ----------------------------------------------------------------
	srh_state_t          state_reg;
	srh_state_t          state_next;
	srh_pkg::srh_pins_t  pins_reg;
	srh_pkg::srh_pins_t  pins_next;
	srh_pkg::srh_op_t    op_reg;
	srh_pkg::srh_op_t    op_next;
	logic                rdata_reg;
	logic                rdata_next;
	logic                rsp_reg;
	logic                rsp_next;
	logic                done_reg;
	logic                done_next;
	logic                last_rmw_reg;
	logic                last_rmw_next;
	logic [TW-1:0]       phase_el;
	logic [TW-1:0]       start_el;
	logic                hold_done;

	wire phase_restart = (state_next != state_reg);
	wire ce_falls      = (state_reg == ST_SETUP) &&
		(state_next == ST_ACTIVE);

	srh_powerup #(
		.HOLD_CYC (POWERUP_CYC)
	) u_powerup (
		.clk     (clk),
		.sys_rst (sys_rst),
		.ready   (hold_done)
	);

	// per-state timer, restarted on every state change
	srh_interval #(
		.W (TW)
	) u_phase (
		.clk     (clk),
		.sys_rst (sys_rst),
		.restart (phase_restart),
		.elapsed (phase_el)
	);

	// start-to-start timer: spacing counts from the last chip strobe fall
	srh_interval #(
		.W (TW)
	) u_start (
		.clk     (clk),
		.sys_rst (sys_rst),
		.restart (ce_falls),
		.elapsed (start_el)
	);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire req_fire = req_valid && req_ready;
	wire mod_fire = mod_valid && mod_ready;
	wire gap_ok   = last_rmw_reg ? (start_el >= RMW_LAST) :
		(start_el >= CYC_LAST);
	wire act_done = (phase_el >= ACT_LAST);
	wire we_done  = (phase_el >= WE_LAST);
	wire pre_done = (phase_el >= PRE_LAST);
	wire mod_late = (start_el >= MOD_LAST);
	wire is_read  = (op_reg == srh_pkg::SRH_OP_READ);
	wire is_rmw   = (op_reg == srh_pkg::SRH_OP_RMW);
	// an early write has nothing to sample: the output stays off
	wire take_bit = is_read || is_rmw;

	assign req_ready  = (state_reg == ST_IDLE);
	assign mod_ready  = (state_reg == ST_MODIFY);
	assign rsp_valid  = rsp_reg;
	assign rsp_rdata  = rdata_reg;
	assign op_done    = done_reg;
	assign link_ready = (state_reg != ST_POWERUP);
	assign mem        = pins_reg;

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_next    = state_reg;
		pins_next     = pins_reg;
		op_next       = op_reg;
		rdata_next    = rdata_reg;
		rsp_next      = 1'b0;
		done_next     = 1'b0;
		last_rmw_next = last_rmw_reg;
		case (state_reg)
			ST_POWERUP: begin
				if (hold_done)
					state_next = ST_IDLE;
			end
			ST_IDLE: begin
				if (req_fire) begin
					// address and data go out a full cycle before ce falls
					op_next                 = req.op;
					pins_next.addr          = req.addr;
					pins_next.write_data_in = req.wdata;
					pins_next.we_n          =
						(req.op != srh_pkg::SRH_OP_WRITE);
					state_next              = ST_SETUP;
				end
			end
			ST_SETUP: begin
				// waits here while the previous cycle started too recently
				if (gap_ok) begin
					pins_next.ce_n = 1'b0;
					state_next     = ST_ACTIVE;
				end
			end
			ST_ACTIVE: begin
				// early write keeps we low with ce: output stays off
				if (act_done) begin
					if (take_bit) begin
						rdata_next = mem_dout;
						rsp_next   = 1'b1;
					end
					if (is_rmw) begin
						state_next = ST_MODIFY;
					end else begin
						pins_next.ce_n = 1'b1;
						pins_next.we_n = 1'b1;
						done_next      = 1'b1;
						last_rmw_next  = 1'b0;
						state_next     = ST_PRECHARGE;
					end
				end
			end
			ST_MODIFY: begin
				// a user that stalls too long gets the old bit written back
				if (mod_fire) begin
					pins_next.write_data_in = mod_wdata;
					state_next              = ST_DATA;
				end else if (mod_late) begin
					pins_next.write_data_in = rdata_reg;
					state_next              = ST_DATA;
				end
			end
			ST_DATA: begin
				pins_next.we_n = 1'b0;
				state_next     = ST_WRITE;
			end
			ST_WRITE: begin
				if (we_done) begin
					pins_next.ce_n = 1'b1;
					pins_next.we_n = 1'b1;
					done_next      = 1'b1;
					last_rmw_next  = 1'b1;
					state_next     = ST_PRECHARGE;
				end
			end
			ST_PRECHARGE: begin
				// the memory output is never sampled here: it is letting go
				if (pre_done)
					state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg    <= ST_POWERUP;
			pins_reg     <= '{ce_n: 1'b1, we_n: 1'b1,
				addr: '0, write_data_in: 1'b0};
			op_reg       <= srh_pkg::SRH_OP_READ;
		end else begin
			state_reg    <= state_next;
			pins_reg     <= pins_next;
			op_reg       <= op_next;
		end
	end

	// status flags apart from the strobe pins so each block stays short
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_reg    <= 1'b0;
			rsp_reg      <= 1'b0;
			done_reg     <= 1'b0;
			last_rmw_reg <= 1'b0;
		end else begin
			rdata_reg    <= rdata_next;
			rsp_reg      <= rsp_next;
			done_reg     <= done_next;
			last_rmw_reg <= last_rmw_next;
		end
	end

endmodule : srh_ctrl

// ---- src/srh_pkg.sv ----
package srh_pkg;

	// ----------------------------------------------------------------
	// clock and array shape
	// ----------------------------------------------------------------
	localparam int CLK_NS = 10;
	localparam int ADDR_W = 12;
	localparam int WORDS  = 4096;

	// ----------------------------------------------------------------
	// pin timing in ns (fastest grade)
	// ----------------------------------------------------------------
	localparam int POWERUP_NS    = 2_000_000;
	localparam int ACCESS_NS     = 200;
	localparam int ACT_MIN_NS    = 200;
	localparam int ACT_MAX_NS    = 10_000;
	localparam int PRECHARGE_NS  = 100;
	localparam int CYCLE_NS      = 310;
	localparam int RMW_NS        = 385;
	localparam int WE_PULSE_NS   = 60;
	localparam int WE_LEAD_NS    = 70;
	localparam int DHOLD_WE_NS   = 70;
	localparam int DHOLD_CE_NS   = 170;
	localparam int WE_HOLD_NS    = 150;

	// least times round up, longest times round down, never below one
	function automatic int cyc_min(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction : cyc_min

	function automatic int cyc_max(input int ns);
		int c;
		c = ns / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction : cyc_max

	// ----------------------------------------------------------------
	// the same figures in clock cycles
	// ----------------------------------------------------------------
	localparam int POWERUP_CYC   = cyc_min(POWERUP_NS);
	localparam int ACCESS_CYC    = cyc_min(ACCESS_NS);
	localparam int ACT_MIN_CYC   = cyc_min(ACT_MIN_NS);
	localparam int ACT_MAX_CYC   = cyc_max(ACT_MAX_NS);
	localparam int PRECHARGE_CYC = cyc_min(PRECHARGE_NS);
	localparam int CYCLE_CYC     = cyc_min(CYCLE_NS);
	localparam int RMW_CYC       = cyc_min(RMW_NS);
	localparam int WE_PULSE_CYC  = cyc_min(WE_PULSE_NS);
	localparam int WE_LEAD_CYC   = cyc_min(WE_LEAD_NS);
	localparam int DHOLD_WE_CYC  = cyc_min(DHOLD_WE_NS);
	localparam int DHOLD_CE_CYC  = cyc_min(DHOLD_CE_NS);
	localparam int WE_HOLD_CYC   = cyc_min(WE_HOLD_NS);

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SRH_OP_READ,
		SRH_OP_WRITE,
		SRH_OP_RMW
	} srh_op_t;

	typedef struct packed {
		srh_op_t             op;
		logic [ADDR_W-1:0]   addr;
		logic                wdata;
	} srh_req_t;

	typedef struct packed {
		logic                ce_n;
		logic                we_n;
		logic [ADDR_W-1:0]   addr;
		logic                write_data_in;
	} srh_pins_t;

endpackage : srh_pkg

// ---- src/srh_interval.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// saturating count of edges since the last restart
// ----------------------------------------------------------------
module srh_interval #(
	parameter int W = 11
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         restart,
	output logic [W-1:0]      elapsed
);

	generate
		if (W < 2) begin : g_bad_w
			$error("srh_interval: W must be at least 2");
		end
	endgenerate

	logic [W-1:0] elapsed_reg;
	logic [W-1:0] elapsed_next;

	// reset to saturated so nothing waits on a first cycle
	assign elapsed_next = restart ? '0 :
		((&elapsed_reg) ? elapsed_reg : elapsed_reg + W'(1));
	assign elapsed      = elapsed_reg;

	always_ff @(posedge clk) begin
		if (sys_rst)
			elapsed_reg <= '1;
		else
			elapsed_reg <= elapsed_next;
	end

endmodule : srh_interval

// ---- src/srh_powerup.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// hold-off after reset release; reset is taken as supply good
// ----------------------------------------------------------------
module srh_powerup #(
	parameter int HOLD_CYC = 200000
) (
	input  wire logic   clk,
	input  wire logic   sys_rst,
	output logic        ready
);

	localparam int CW = $clog2(HOLD_CYC + 1);

	generate
		if (HOLD_CYC < 1) begin : g_bad_hold
			$error("srh_powerup: HOLD_CYC must be at least 1");
		end
	endgenerate

	logic [CW-1:0] count_reg;
	logic [CW-1:0] count_next;
	logic          ready_reg;
	logic          ready_next;

	assign ready_next = (count_reg >= CW'(HOLD_CYC - 1));
	assign count_next = ready_next ? count_reg : count_reg + CW'(1);
	assign ready      = ready_reg;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			count_reg <= '0;
			ready_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			ready_reg <= ready_next;
		end
	end

endmodule : srh_powerup

// ---- tb/srh_ctrl_properties.sv ----
`timescale 1ns/1ps

// ------
// strobe timing watch
// ------
module srh_chk #(
	parameter int POWERUP_CYC   = 20,
	parameter int ACT_MIN_CYC   = 20,
	parameter int ACT_MAX_CYC   = 1000,
	parameter int PRECHARGE_CYC = 10,
	parameter int CYCLE_CYC     = 31,
	parameter int RMW_CYC       = 39
) (
	input wire logic               clk,
	input wire logic               sys_rst,
	input wire srh_pkg::srh_pins_t mem
);
	int   up, lo, hi, fa, wl;
	logic rmw;
	wire  ce = mem.ce_n;
	wire  we = mem.we_n;

	// far-out start keeps the first cycle after reset legal
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			up  <= 0;
			lo  <= 0;
			hi  <= 9999;
			fa  <= 9999;
			wl  <= 0;
			rmw <= 1'b0;
		end else begin
			up  <= (up < POWERUP_CYC) ? up + 1 : up;
			lo  <= ce ? 0 : lo + 1;
			hi  <= ce ? hi + 1 : 0;
			fa  <= $fell(ce) ? 1 : fa + 1;
			wl  <= we ? 0 : wl + 1;
			rmw <= $fell(ce) ? 1'b0 : rmw || ($fell(we) && !ce);
		end
	end

	default clocking dcb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	pwr_hold_a: assert property (
		up < POWERUP_CYC |-> ce && we) else $error("strobe in hold-off");
	we_setup_a: assert property (
		$fell(ce) |-> we == $past(we)) else $error("we moved at ce fall");
	act_min_a: assert property (
		$rose(ce) |-> lo >= ACT_MIN_CYC) else $error("ce pulse short");
	act_max_a: assert property (
		!ce |-> lo < ACT_MAX_CYC) else $error("ce pulse long");
	precharge_a: assert property (
		$fell(ce) |-> hi >= PRECHARGE_CYC) else $error("precharge short");
	cycle_gap_a: assert property (
		$fell(ce) |-> fa >= (rmw ? RMW_CYC : CYCLE_CYC))
		else $error("cycles too close");
	data_hold_a: assert property (
		!ce && !we && !$past(we) |-> $stable(mem.write_data_in))
		else $error("write data moved");
	we_pulse_a: assert property (
		$rose(we) |-> wl >= srh_pkg::WE_PULSE_CYC
			&& lo >= srh_pkg::WE_HOLD_CYC) else $error("we pulse short");
	we_lead_a: assert property (
		$rose(ce) && !$past(we) |-> wl >= srh_pkg::WE_LEAD_CYC)
		else $error("we lead short");
endmodule : srh_chk

bind srh_ctrl srh_chk #(
	.POWERUP_CYC  (POWERUP_CYC),
	.ACT_MIN_CYC  (ACT_MIN_CYC),
	.ACT_MAX_CYC  (ACT_MAX_CYC),
	.PRECHARGE_CYC(PRECHARGE_CYC),
	.CYCLE_CYC    (CYCLE_CYC),
	.RMW_CYC      (RMW_CYC)
) u_chk (
	.clk    (clk),
	.sys_rst(sys_rst),
	.mem    (mem)
);

// ---- tb/srh_ram_model.sv ----
`timescale 1ns/1ps

// ------
// 4096 x 1 memory on the far side
// ------
module srh_ram_model #(
	parameter int ACC_CYC = 20 // raise for a slower part
) (
	input  wire logic               clk,
	input  wire srh_pkg::srh_pins_t mem,
	output logic                    mem_dout
);
	logic        arr [4096]; // static cells, no refresh
	logic [11:0] a;
	logic        pce = 1'b1;
	logic        rd, wlat, wbit;
	int          cnt;

	initial mem_dout = 1'b0;

	always @(posedge clk) begin
		pce <= mem.ce_n;
		cnt <= cnt + 1;
		if (pce && !mem.ce_n) begin
			a    <= mem.addr;
			rd   <= mem.we_n;
			cnt  <= 1;
			wlat <= 1'b0;
		end
		// data taken on the later of the two strobe falls
		if (!mem.ce_n && !mem.we_n && (pce || !wlat)) begin
			wbit <= mem.write_data_in;
			wlat <= 1'b1;
		end
		if (!pce && mem.ce_n && wlat)
			arr[a] <= wbit;
		// undriven output wanders so a stale bit never reads as good
		if (!pce && !mem.ce_n && rd && cnt >= ACC_CYC - 1)
			mem_dout <= arr[a];
		else
			mem_dout <= ~mem_dout;
	end
endmodule : srh_ram_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps

// ------
// bench
// ------
module tb_top;
	localparam int PU = 20; // short hold-off keeps the run brief

	logic               clk, sys_rst, req_valid, mod_valid, mod_wdata;
	logic               req_ready, rsp_valid, rsp_rdata, mod_ready;
	logic               op_done, link_ready, mem_dout, r;
	srh_pkg::srh_req_t  req;
	srh_pkg::srh_pins_t mem;
	int                 bad_count = 0;
	int                 n_tests = 0;

	srh_ctrl #(.POWERUP_CYC(PU)) u_dut (
		.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
		.req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .mod_ready(mod_ready),
		.mod_valid(mod_valid), .mod_wdata(mod_wdata), .op_done(op_done),
		.link_ready(link_ready), .mem(mem), .mem_dout(mem_dout)
	);
	srh_ram_model u_ram (.clk(clk), .mem(mem), .mem_dout(mem_dout));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic tick;
		@(posedge clk);
		#1;
	endtask : tick

	task automatic chk(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t: got %b want %b", $time, got, exp);
		end
	endtask : chk

	// request held until an edge that sees req_ready high
	task automatic run(input srh_pkg::srh_op_t op, input logic [11:0] a,
		input logic d, input logic sup);
		int n;
		n = 0;
		r = 1'bx;
		req = '{op, a, d};
		mod_wdata = d;
		req_valid = 1'b1;
		while (req_ready !== 1'b1 && n < 100) begin
			tick();
			n++;
		end
		tick();
		req_valid = 1'b0;
		do begin
			tick();
			n++;
			if (rsp_valid === 1'b1)
				r = rsp_rdata;
			mod_valid = sup && mod_ready === 1'b1;
		end while (op_done !== 1'b1 && n < 1200);
		chk(op_done, 1'b1);
	endtask : run

	task automatic t_power;
		repeat (PU) begin
			chk(link_ready | ~mem.ce_n | ~mem.we_n, 1'b0);
			tick();
		end
		tick();
		tick();
		chk(link_ready, 1'b1);
	endtask : t_power

	task automatic t_rw;
		logic [11:0] ad [4];
		ad = '{12'h000, 12'hfff, 12'h5a5, 12'h5a4};
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 4; i++)
				run(srh_pkg::SRH_OP_WRITE, ad[i], i[0] ^ p[0], 1'b0);
			for (int i = 0; i < 4; i++) begin
				run(srh_pkg::SRH_OP_READ, ad[i], 1'b0, 1'b0);
				chk(r, i[0] ^ p[0]);
			end
		end
	endtask : t_rw

	task automatic t_rmw;
		run(srh_pkg::SRH_OP_RMW, 12'h5a5, 1'b0, 1'b1);
		chk(r, 1'b1);
		run(srh_pkg::SRH_OP_RMW, 12'h5a5, 1'b1, 1'b1);
		chk(r, 1'b0);
		run(srh_pkg::SRH_OP_RMW, 12'hfff, 1'b1, 1'b0);
		chk(r, 1'b0);
		run(srh_pkg::SRH_OP_READ, 12'hfff, 1'b0, 1'b0);
		chk(r, 1'b0);
		run(srh_pkg::SRH_OP_READ, 12'h5a5, 1'b0, 1'b0);
		chk(r, 1'b1);
	endtask : t_rmw

	task automatic t_rst;
		repeat (300) begin
			tick();
			chk(mem.ce_n, 1'b1);
		end
		run(srh_pkg::SRH_OP_READ, 12'h000, 1'b0, 1'b0);
		chk(r, 1'b1);
		req = '{srh_pkg::SRH_OP_WRITE, 12'h0f0, 1'b1};
		req_valid = 1'b1;
		repeat (18) tick();
		sys_rst = 1'b1;
		req_valid = 1'b0;
		repeat (5) tick();
		sys_rst = 1'b0;
		t_power();
		run(srh_pkg::SRH_OP_READ, 12'h5a4, 1'b0, 1'b0);
		chk(r, 1'b0);
	endtask : t_rst

	task automatic test_done;
		if (bad_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done

	initial begin
		sys_rst = 1'b1;
		{req_valid, mod_valid, mod_wdata} = 3'h0;
		req = '0;
		repeat (5) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		t_power();
		t_rw();
		t_rmw();
		t_rst();
		test_done();
	end

	// about nine times the two thousand or so cycles the tests need
	initial begin
		#200000;
		bad_count++;
		test_done();
	end
endmodule : tb_top
